// [shared/mspeed_pkg.sv]
// constants, types and speed decode shared by the multi-speed selector
//
// Contract
// - high, middle, low selects pick 60/30/10 Hz
// - several basic selects with a 9999 speed preset: lowest-ranked select wins
// - select combinations pick speeds 4 to 15
// - 9999 marks speed unusable; reset value of speeds 4 to 15
// - speed 8 is extra only; low preset while speed 8 holds 9999
// - terminal code 8 attaches extra select
// - terminal codes 0,1,2 attach low, middle, high
// - reset maps selects to their dedicated terminals
// - presets writable anytime, regardless of write protect
// - presets 0 to 400 Hz, 9999 for 4-15
// - remote setting turns selects into up/down/clear
package mspeed_pkg;

	////////////////////////////////////////////////////////////////////////////
	// sizes
	localparam int NUM_SPEEDS = 15;
	localparam int NUM_TERMS  = 12;
	localparam int FREQ_W     = 14;
	localparam int TCODE_W    = 8;

	typedef logic [FREQ_W-1:0]  freq_t;    // frequency in 0.1 Hz steps
	typedef logic [TCODE_W-1:0] tcode_t;
	typedef logic [3:0]         speed_t;
	typedef logic [1:0]         remote_t;
	typedef logic [NUM_SPEEDS:1][FREQ_W-1:0] bank_t;

	////////////////////////////////////////////////////////////////////////////
	// preset values and limits (0.1 Hz units, sentinel is the raw code)
	localparam freq_t FREQ_MAX   = 14'h0FA0;  // 400.0 Hz
	localparam freq_t FREQ_NONE  = 14'h270F;  // 9999, speed not selected
	localparam freq_t RST_HIGH   = 14'h0258;  // 60.0 Hz
	localparam freq_t RST_MIDDLE = 14'h012C;  // 30.0 Hz
	localparam freq_t RST_LOW    = 14'h0064;  // 10.0 Hz

	////////////////////////////////////////////////////////////////////////////
	// speed numbers
	localparam speed_t SPD_IDLE   = 4'h0;
	localparam speed_t SPD_HIGH   = 4'h1;
	localparam speed_t SPD_MIDDLE = 4'h2;
	localparam speed_t SPD_LOW    = 4'h3;
	localparam speed_t SPD_FIRST_EXT = 4'h4;

	////////////////////////////////////////////////////////////////////////////
	// terminal function codes and reset assignment
	localparam tcode_t FUNC_LOW    = 8'h00;
	localparam tcode_t FUNC_MIDDLE = 8'h01;
	localparam tcode_t FUNC_HIGH   = 8'h02;
	localparam tcode_t FUNC_EXTRA  = 8'h08;
	localparam tcode_t FUNC_NONE   = 8'hFF;   // no select function
	localparam int     TERM_LOW    = 0;       // dedicated low terminal
	localparam int     TERM_MIDDLE = 1;
	localparam int     TERM_HIGH   = 2;

	localparam remote_t REMOTE_OFF = 2'h0;

	////////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic extra;
		logic high;
		logic middle;
		logic low;
	} sel_t;

	typedef struct packed {
		logic   en;
		speed_t idx;
		freq_t  val;
	} preset_wr_t;

	typedef struct packed {
		logic   valid;
		speed_t speed;
		freq_t  freq;
	} freq_cmd_t;

	typedef struct packed {
		logic up;
		logic down;
		logic clear;
	} remote_cmd_t;

	////////////////////////////////////////////////////////////////////////////
	// select combination to speed number
	function automatic speed_t speed_of(input sel_t s);
		unique case ({s.extra, s.high, s.middle, s.low})
			4'h4: speed_of = 4'h1;
			4'h2: speed_of = 4'h2;
			4'h1: speed_of = 4'h3;
			4'h3: speed_of = 4'h4;
			4'h5: speed_of = 4'h5;
			4'h6: speed_of = 4'h6;
			4'h7: speed_of = 4'h7;
			4'h8: speed_of = 4'h8;
			4'h9: speed_of = 4'h9;
			4'hA: speed_of = 4'hA;
			4'hB: speed_of = 4'hB;
			4'hC: speed_of = 4'hC;
			4'hD: speed_of = 4'hD;
			4'hE: speed_of = 4'hE;
			4'hF: speed_of = 4'hF;
			4'h0: speed_of = SPD_IDLE;
		endcase
	endfunction : speed_of

endpackage : mspeed_pkg

// [hw/preset_store.sv]
// storage of the fifteen speed presets with range-checked writes
`timescale 1ns/1ps
`default_nettype none
module preset_store
	import mspeed_pkg::*;
(
	// clock and reset
	input  wire logic                   clk_in,
	input  wire logic                   rst_in,
	// write request
	input  wire mspeed_pkg::preset_wr_t wr_in,
	// presets and write result
	output logic                        ack_out,
	output logic                        err_out,
	output mspeed_pkg::bank_t           bank_out
);

	typedef struct packed {
		bank_t bank;
		logic  ack;
		logic  err;
	} store_t;

	store_t st_q;
	store_t st_d;

	////////////////////////////////////////////////////////////////////////////
	// value check and update
	always_comb begin
		logic legal;
		legal = 1'b0;
		st_d = st_q;
		st_d.ack = 1'b0;
		st_d.err = 1'b0;
		if (wr_in.val <= FREQ_MAX) begin
			legal = 1'b1;
		end else if (wr_in.val == FREQ_NONE && wr_in.idx >= SPD_FIRST_EXT) begin
			legal = 1'b1;
		end
		if (wr_in.idx == SPD_IDLE) begin
			legal = 1'b0;
		end
		// accepted whatever the run state or write protection
		if (wr_in.en) begin
			if (legal) begin
				st_d.bank[wr_in.idx] = wr_in.val;
				st_d.ack = 1'b1;
			end else begin
				st_d.err = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// registers with documented reset presets
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			for (int i = 1; i <= NUM_SPEEDS; i++) begin
				st_q.bank[i] <= FREQ_NONE;
			end
			st_q.bank[SPD_HIGH]   <= RST_HIGH;
			st_q.bank[SPD_MIDDLE] <= RST_MIDDLE;
			st_q.bank[SPD_LOW]    <= RST_LOW;
			st_q.ack <= 1'b0;
			st_q.err <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	assign ack_out  = st_q.ack;
	assign err_out  = st_q.err;
	assign bank_out = st_q.bank;

endmodule : preset_store
`default_nettype wire

// [hw/multi_speed_selector.sv]
// multi-speed frequency selector: terminal routing, speed decode, preset pick
`timescale 1ns/1ps
`default_nettype none
module multi_speed_selector
	import mspeed_pkg::*;
(
	// clock and reset
	input  wire logic                    CLK_SYS_IN,
	input  wire logic                    SYS_RST_IN,
	// contact input terminals
	input  wire logic [11:0]             TERM_IN,
	// remote setting selection
	input  wire mspeed_pkg::remote_t     REMOTE_SEL_IN,
	// terminal function selection write
	input  wire logic                    TSEL_WR_IN,
	input  wire logic [3:0]              TSEL_IDX_IN,
	input  wire mspeed_pkg::tcode_t      TSEL_CODE_IN,
	// preset write
	input  wire mspeed_pkg::preset_wr_t  PRESET_WR_IN,
	output logic                         PRESET_ACK_OUT,
	output logic                         PRESET_ERR_OUT,
	// frequency command and remote commands
	output mspeed_pkg::freq_cmd_t        FREQ_CMD_OUT,
	output mspeed_pkg::remote_cmd_t      REMOTE_CMD_OUT
);

	import mspeed_pkg::*;

	typedef struct packed {
		logic [NUM_TERMS-1:0][TCODE_W-1:0] tsel;
		freq_cmd_t                         cmd;
		remote_cmd_t                       remote;
	} state_t;

	state_t st_q;
	state_t st_d;
	bank_t  bank;
	sel_t   sel;

	////////////////////////////////////////////////////////////////////////////
	// terminal code to select bit, used for every function
	function automatic logic routed(input logic [NUM_TERMS-1:0] terms,
	                                input logic [NUM_TERMS-1:0][TCODE_W-1:0] tsel,
	                                input tcode_t code);
		routed = 1'b0;
		for (int t = 0; t < NUM_TERMS; t++) begin
			if (tsel[t] == code && terms[t]) begin
				routed = 1'b1;
			end
		end
	endfunction : routed

	////////////////////////////////////////////////////////////////////////////
	// preset storage
	preset_store u_store (
		.clk_in   (CLK_SYS_IN),
		.rst_in   (SYS_RST_IN),
		.wr_in    (PRESET_WR_IN),
		.ack_out  (PRESET_ACK_OUT),
		.err_out  (PRESET_ERR_OUT),
		.bank_out (bank)
	);

	////////////////////////////////////////////////////////////////////////////
	// select functions gathered from the assigned terminals
	always_comb begin
		sel.low    = routed(TERM_IN, st_q.tsel, FUNC_LOW);
		sel.middle = routed(TERM_IN, st_q.tsel, FUNC_MIDDLE);
		sel.high   = routed(TERM_IN, st_q.tsel, FUNC_HIGH);
		sel.extra  = routed(TERM_IN, st_q.tsel, FUNC_EXTRA);
	end

	////////////////////////////////////////////////////////////////////////////
	// next state: assignment writes, speed pick, remote commands
	always_comb begin
		speed_t spd;
		freq_t  pick;
		speed_t fb_spd;
		spd    = SPD_IDLE;
		pick   = FREQ_NONE;
		fb_spd = SPD_LOW;
		st_d = st_q;

		// terminal function assignment, out-of-range index ignored
		if (TSEL_WR_IN && TSEL_IDX_IN < 4'(NUM_TERMS)) begin
			st_d.tsel[TSEL_IDX_IN] = TSEL_CODE_IN;
		end

		// fallback: lowest-ranked basic select, low preset if none
		if (sel.low) begin
			fb_spd = SPD_LOW;
		end else if (sel.middle) begin
			fb_spd = SPD_MIDDLE;
		end else if (sel.high) begin
			fb_spd = SPD_HIGH;
		end else begin
			fb_spd = SPD_LOW;
		end

		spd = speed_of(sel);
		if (spd != SPD_IDLE) begin
			pick = bank[spd];
		end
		// unused speed falls back to a basic preset
		if (spd >= SPD_FIRST_EXT && pick == FREQ_NONE) begin
			spd  = fb_spd;
			pick = bank[fb_spd];
		end

		st_d.remote = '0;
		if (REMOTE_SEL_IN != REMOTE_OFF) begin
			// selects become up, down and clear
			st_d.cmd.valid     = 1'b0;
			st_d.cmd.speed     = SPD_IDLE;
			st_d.cmd.freq      = '0;
			st_d.remote.up     = sel.high;
			st_d.remote.down   = sel.middle;
			st_d.remote.clear  = sel.low;
		end else if (spd == SPD_IDLE) begin
			// leave the command to the other source
			st_d.cmd.valid = 1'b0;
			st_d.cmd.speed = SPD_IDLE;
			st_d.cmd.freq  = '0;
		end else begin
			st_d.cmd.valid = 1'b1;
			st_d.cmd.speed = spd;
			st_d.cmd.freq  = pick;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// state registers
	always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			for (int t = 0; t < NUM_TERMS; t++) begin
				st_q.tsel[t] <= FUNC_NONE;
			end
			st_q.tsel[TERM_LOW]    <= FUNC_LOW;
			st_q.tsel[TERM_MIDDLE] <= FUNC_MIDDLE;
			st_q.tsel[TERM_HIGH]   <= FUNC_HIGH;
			st_q.cmd    <= '0;
			st_q.remote <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign FREQ_CMD_OUT   = st_q.cmd;
	assign REMOTE_CMD_OUT = st_q.remote;

endmodule : multi_speed_selector
`default_nettype wire

// [verif/mspeed_asserts.sv]
// assertions on the multi-speed selector top ports
`timescale 1ns/1ps
`default_nettype none
module mspeed_asserts
	import mspeed_pkg::*;
(
	// clock and reset
	input wire logic                   CLK_SYS_IN,
	input wire logic                   SYS_RST_IN,
	// watched inputs
	input wire logic [11:0]            TERM_IN,
	input wire mspeed_pkg::remote_t    REMOTE_SEL_IN,
	input wire mspeed_pkg::preset_wr_t PRESET_WR_IN,
	// watched outputs
	input wire logic                   PRESET_ACK_OUT,
	input wire logic                   PRESET_ERR_OUT,
	input wire mspeed_pkg::freq_cmd_t  FREQ_CMD_OUT,
	input wire mspeed_pkg::remote_cmd_t REMOTE_CMD_OUT
);
	default clocking cb @(posedge CLK_SYS_IN); endclocking
	default disable iff (SYS_RST_IN);
	////////////////////////////////////////////////////////////////
	// preset write answers, one cycle after the request
	wr_answer_a: assert property (PRESET_WR_IN.en |=> PRESET_ACK_OUT != PRESET_ERR_OUT)
		else $error("preset write not answered once");
	no_spurious_a: assert property (!PRESET_WR_IN.en |=> !PRESET_ACK_OUT && !PRESET_ERR_OUT)
		else $error("answer without preset write");
	zero_idx_a: assert property (PRESET_WR_IN.en && PRESET_WR_IN.idx == 4'h0 |=> PRESET_ERR_OUT)
		else $error("speed zero write not refused");
	over_range_a: assert property (PRESET_WR_IN.en && PRESET_WR_IN.val > FREQ_MAX
		&& PRESET_WR_IN.val != FREQ_NONE |=> PRESET_ERR_OUT)
		else $error("out of range preset accepted");
	in_range_a: assert property (PRESET_WR_IN.en && PRESET_WR_IN.idx != 4'h0
		&& PRESET_WR_IN.val <= FREQ_MAX |=> PRESET_ACK_OUT)
		else $error("legal preset refused");
	basic_none_a: assert property (PRESET_WR_IN.en && PRESET_WR_IN.val == FREQ_NONE
		&& PRESET_WR_IN.idx inside {[1:3]} |=> PRESET_ERR_OUT)
		else $error("sentinel accepted for basic speed");
	ext_none_a: assert property (PRESET_WR_IN.en && PRESET_WR_IN.val == FREQ_NONE
		&& PRESET_WR_IN.idx >= 4'h4 |=> PRESET_ACK_OUT)
		else $error("sentinel refused for extended speed");
	// frequency and remote commands
	remote_cmd_a: assert property (REMOTE_SEL_IN != REMOTE_OFF |=> !FREQ_CMD_OUT.valid)
		else $error("preset command in remote mode");
	remote_idle_a: assert property (REMOTE_SEL_IN == REMOTE_OFF |=> REMOTE_CMD_OUT == '0)
		else $error("remote command outside remote mode");
	idle_cmd_a: assert property (TERM_IN == 12'h000 |=> FREQ_CMD_OUT == '0)
		else $error("preset command with no select");
	cmd_range_a: assert property (FREQ_CMD_OUT.valid |-> FREQ_CMD_OUT.freq <= FREQ_MAX
		&& FREQ_CMD_OUT.speed != SPD_IDLE)
		else $error("command speed or frequency illegal");
	// main scenarios
	cover property (PRESET_WR_IN.en && PRESET_WR_IN.val == FREQ_NONE ##1 PRESET_ACK_OUT);
	cover property (REMOTE_SEL_IN != REMOTE_OFF ##1 !FREQ_CMD_OUT.valid);
	cover property (FREQ_CMD_OUT.valid && FREQ_CMD_OUT.speed > SPD_LOW);
endmodule : mspeed_asserts
bind multi_speed_selector mspeed_asserts u_mspeed_asserts (
	.CLK_SYS_IN(CLK_SYS_IN), .SYS_RST_IN(SYS_RST_IN), .TERM_IN(TERM_IN),
	.REMOTE_SEL_IN(REMOTE_SEL_IN), .PRESET_WR_IN(PRESET_WR_IN),
	.PRESET_ACK_OUT(PRESET_ACK_OUT), .PRESET_ERR_OUT(PRESET_ERR_OUT),
	.FREQ_CMD_OUT(FREQ_CMD_OUT), .REMOTE_CMD_OUT(REMOTE_CMD_OUT));
`default_nettype wire

// [verif/contact_bank.sv]
// contact switch model driving the selector terminals
`timescale 1ns/1ps
`default_nettype none
module contact_bank (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// requested contact pattern and terminal levels
	input  wire logic [11:0] pat_in,
	output logic      [11:0] term_out
);
	// contacts settle on the edge after the controller asks
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) term_out <= 12'h000;
		else term_out <= pat_in;
	end
endmodule : contact_bank
`default_nettype wire

// [verif/tb_top.sv]
// self-checking bench for the multi-speed selector
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
	import mspeed_pkg::*;
	logic        clk, rst, twr, ack, err, e_ack, e_err, e_rem;
	logic [11:0] pat, term;
	logic [3:0]  tidx;
	remote_t     rsel;
	tcode_t      tcode;
	preset_wr_t  pwr;
	freq_cmd_t   cmd, e_cmd;
	remote_cmd_t rcmd, e_rc;
	int          fail_count, checks, pre[1:15], code[0:11];
	bit [31:0]   seed = 32'hA489;
	////////////////////////////////////////////////////////////////
	contact_bank u_contact_bank (.clk_in(clk), .rst_in(rst), .pat_in(pat), .term_out(term));
	multi_speed_selector u_multi_speed_selector (.CLK_SYS_IN(clk), .SYS_RST_IN(rst),
		.TERM_IN(term), .REMOTE_SEL_IN(rsel), .TSEL_WR_IN(twr), .TSEL_IDX_IN(tidx),
		.TSEL_CODE_IN(tcode), .PRESET_WR_IN(pwr), .PRESET_ACK_OUT(ack),
		.PRESET_ERR_OUT(err), .FREQ_CMD_OUT(cmd), .REMOTE_CMD_OUT(rcmd));
	////////////////////////////////////////////////////////////////
	function automatic bit [31:0] xorshift();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xorshift
	task automatic tally_and_finish();
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : tally_and_finish
	// reference model, sees inputs as they stood at the edge
	always @(posedge clk) begin : model
		sel_t s;
		int   sp;
		if (rst) begin
			for (int i = 1; i <= 15; i++) pre[i] = (i > 3) ? 9999 : (i == 1) ? 600 : (i == 2) ? 300 : 100;
			foreach (code[i]) code[i] = (i < 3) ? i : 255;
			e_cmd = '0;
			e_rc = '0;
			{e_ack, e_err, e_rem} = 3'h0;
		end else begin
			s = '0;
			foreach (code[i]) if (term[i]) case (code[i])
				0: s.low = 1'b1;
				1: s.middle = 1'b1;
				2: s.high = 1'b1;
				8: s.extra = 1'b1;
				default: ;
			endcase
			sp = int'(s);
			sp = (sp == 4) ? 1 : (sp == 2) ? 2 : (sp == 1) ? 3 : (sp == 3) ? 4 : sp;
			if (sp >= 4 && pre[sp] == 9999) sp = s.low ? 3 : s.middle ? 2 : s.high ? 1 : 3;
			e_rem = rsel != 2'h0;
			e_cmd = (sp == 0 || e_rem) ? '0 : {1'b1, 4'(sp), 14'(pre[sp])};
			e_rc = e_rem ? {s.high, s.middle, s.low} : 3'h0;
			e_err = pwr.en && (pwr.idx == 0 || (pwr.val > 4000 && !(pwr.val == 9999 && pwr.idx >= 4)));
			e_ack = pwr.en && !e_err;
			if (e_ack) pre[pwr.idx] = pwr.val;
			if (twr && tidx < 12) code[tidx] = tcode;
		end
	end
	// compare settled outputs mid-cycle
	always @(negedge clk) if (!rst) begin
		`CHK(cmd.valid, e_cmd.valid)
		`CHK(cmd, e_cmd)
		`CHK(rcmd, e_rc)
		`CHK({ack, err}, {e_ack, e_err})
	end
	// clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// watchdog
	initial begin
		#200000;
		fail_count++;
		tally_and_finish();
	end
	// stimulus: defaults, extra select on terminal 3, then random traffic
	initial begin : main
		bit [31:0] r, q;
		rst = 1'b1;
		{pat, rsel, twr, tidx, tcode, pwr} = '0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			pat <= 12'(i);
		end
		@(posedge clk);
		twr <= 1'b1;
		tidx <= 4'h3;
		tcode <= 8'h08;
		for (int i = 0; i < 16; i++) begin
			@(posedge clk);
			twr <= 1'b0;
			pat <= 12'(i);
		end
		repeat (3000) begin
			@(posedge clk);
			r = xorshift();
			q = xorshift();
			pat <= r[11:0] & q[11:0];
			rsel <= (r[31:29] == 3'h0) ? r[28:27] : 2'h0;
			pwr.en <= r[12];
			pwr.idx <= r[16:13];
			case (r[18:17])
				2'h0: pwr.val <= 14'(q % 4001);
				2'h1: pwr.val <= 14'h270F;
				2'h2: pwr.val <= 14'(4000 + q[1:0]);
				default: pwr.val <= q[13:0];
			endcase
			twr <= &r[21:19];
			tidx <= r[25:22];
			tcode <= q[31] ? q[21:14] : (q[30] ? 8'h08 : {6'h00, q[29:28]});
		end
		// second reset mid-run: written presets and codes must be gone
		@(posedge clk);
		rst <= 1'b1;
		{pat, rsel, twr, tidx, tcode, pwr} <= '0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 16; i++) begin
			@(posedge clk);
			pat <= 12'(i);
		end
		repeat (3) @(posedge clk);
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire
